//--- rtl/spvp_data_latch.sv
// bank of 32 programming data latches indexed by the low address bits
`timescale 1ns/1ns
module spvp_data_latch
   import spvp_pkg::*;
#(
   parameter int WORD_W = 14,
   parameter int DEPTH  = 32
) (
   input  wire logic                     clk_sys,
   spvp_link_if.lat_mp                   lk,
   input  wire logic [$clog2(DEPTH)-1:0] latch_rd_idx,
   output logic      [WORD_W-1:0]        latch_rd_data
);
   logic [WORD_W-1:0] mem_reg [DEPTH];

   // a newer load to the same slot overwrites the older word
   always_ff @(posedge clk_sys) begin
      if (lk.lat_we) begin
         mem_reg[lk.lat_idx] <= lk.lat_word;
      end
      latch_rd_data <= mem_reg[latch_rd_idx];
   end
endmodule // spvp_data_latch

//--- rtl/spvp_defs.svh
// constants of the serial program/verify port
`ifndef SPVP_DEFS_SVH
`define SPVP_DEFS_SVH
// command codes, low five bits only (bit 5 is ignored)
`define SPVP_CMD_LOAD_CFG   5'h00
`define SPVP_CMD_LOAD_DATA  5'h02
`define SPVP_CMD_READ       5'h04
`define SPVP_CMD_INCR       5'h06
`define SPVP_CMD_RST_ADDR   5'h16
`define SPVP_CMD_BEGIN_INT  5'h08
`define SPVP_CMD_BEGIN_EXT  5'h18
`define SPVP_CMD_END_EXT    5'h0A
`define SPVP_CMD_BULK_ERASE 5'h09
`define SPVP_CMD_ROW_ERASE  5'h11
// address map
`define SPVP_ADDR_RST       14'h0000
`define SPVP_CFG_BASE       14'h2000
`define SPVP_PROG_TOP       14'h1FFF
`define SPVP_ADDR_TOP       14'h3FFF
// bit counts: last index of a command and of a data frame
`define SPVP_CMD_LAST       5'h05
`define SPVP_FRAME_LAST     5'h0F
// system clock period in ns; a link clock of 320 ns gives 8 samples
`define SPVP_CLK_PERIOD_NS  40
`endif

//--- rtl/spvp_link_if.sv
// carrier between the pin sampler, the command core and the data latches
`timescale 1ns/1ns
interface spvp_link_if;
   logic        clk_rise;
   logic        clk_fall;
   logic        data_bit;
   logic        mode_on;
   logic        lat_we;
   logic [4:0]  lat_idx;
   logic [13:0] lat_word;
   modport samp_mp (output clk_rise, clk_fall, data_bit, mode_on);
   modport core_mp (input clk_rise, clk_fall, data_bit, mode_on,
                    output lat_we, lat_idx, lat_word);
   modport lat_mp  (input lat_we, lat_idx, lat_word);
endinterface

//--- rtl/spvp_pin_sync.sv
// two-flop sampling of the link pins and edge finding on the serial clock
`timescale 1ns/1ns
module spvp_pin_sync
   import spvp_pkg::*;
(
   input  wire logic    clk_sys,
   input  wire logic    rst,
   input  wire logic    prog_serial_clock,
   input  wire logic    prog_serial_data_in,
   input  wire logic    mode_select_pin,
   spvp_link_if.samp_mp lk
);
   typedef struct packed {
      logic [1:0] ck;
      logic       ck_d;
      logic [1:0] dt;
      logic [1:0] md;
   } spvp_sync_s;
   spvp_sync_s s_reg;
   spvp_sync_s s_next;

   // shift each pin through two flops; ck_d keeps the previous stable clock
   always_comb begin
      s_next      = s_reg;
      s_next.ck   = {s_reg.ck[0], prog_serial_clock};
      s_next.ck_d = s_reg.ck[1];
      s_next.dt   = {s_reg.dt[0], prog_serial_data_in};
      s_next.md   = {s_reg.md[0], mode_select_pin};
   end

   always_ff @(posedge clk_sys) begin
      if (rst) begin
         s_reg <= '0;
      end else begin
         s_reg <= s_next;
      end
   end

   // only the second flops and ck_d are looked at
   assign lk.clk_rise = s_reg.ck[1] & ~s_reg.ck_d;
   assign lk.clk_fall = ~s_reg.ck[1] & s_reg.ck_d;
   assign lk.data_bit = s_reg.dt[1];
   assign lk.mode_on  = s_reg.md[1];
endmodule // spvp_pin_sync

//--- rtl/spvp_pkg.sv
// types of the serial program/verify port
package spvp_pkg;
   typedef enum logic [1:0] {SPVP_ST_CMD, SPVP_ST_DIN, SPVP_ST_DOUT} spvp_state_e;
   typedef enum logic [3:0] {
      SPVP_K_LOAD_CFG, SPVP_K_LOAD_DATA, SPVP_K_READ, SPVP_K_INCR, SPVP_K_RST_ADDR,
      SPVP_K_BEGIN_INT, SPVP_K_BEGIN_EXT, SPVP_K_END_EXT, SPVP_K_BULK, SPVP_K_ROW,
      SPVP_K_NONE
   } spvp_cmd_e;
   typedef struct packed {
      spvp_state_e st;
      logic [4:0]  cnt;
      logic [15:0] sr;
      logic [13:0] addr;
      logic [13:0] rd_word;
      logic        in_cfg;
      logic        loaded;
      logic        ext_busy;
      logic        oe;
      logic        dout;
      logic        lat_we;
      logic [13:0] lat_word;
      logic [4:0]  strobes;
   } spvp_core_s;
endpackage

//--- rtl/spvp_port.sv
// serial program/verify command interpreter, address counter and read shifter
// Behaviour
// - commands and data words travel least significant bit first
// - data changes after serial clock rise, sampled at its fall
// - mode entry resets other logic, floats all I/O, clears address
// - mode pin dropped to supply level or lower ends the mode
// - ten six-bit commands; top command bit ignored
// - data frame is 16 clocks: zero, 14-bit word, zero
// - codes 00h, 02h, 04h load config, load data, read; framed
// - codes 08h, 18h, 0Ah begin internal, begin external, end external
// - codes 09h, 11h bulk erase and row erase, no frame
// - load config sets address 2000h and loads the data latch
// - config space left only by reset-address or mode exit
// - load data fills a latch, written to array only on begin
// - read drives from first fall, bits from second rise, releases after 16th
// - protected program memory reads back as zeros
// - 06h increments; 1FFFh wraps to 0000h, 3FFFh wraps to 2000h
// - 16h forces address to 0000h from any space
// - end external within the window; external not for config words
// - row erase clears 32-word row; ignored if protected or above 2000h
`timescale 1ns/1ns
`include "spvp_defs.svh"
module spvp_port
   import spvp_pkg::*;
(
   input  wire logic        clk_sys,
   input  wire logic        rst,
   input  wire logic        mode_select_pin,
   input  wire logic        prog_serial_clock,
   input  wire logic        prog_serial_data_in,
   output logic             prog_serial_data_out,
   output logic             prog_serial_data_oe,
   input  wire logic        code_protect_n,
   input  wire logic [13:0] mem_rd_data,
   output logic      [13:0] mem_addr,
   output logic             prog_begin_int,
   output logic             prog_begin_ext,
   output logic             prog_end_ext,
   output logic             bulk_erase,
   output logic             row_erase,
   input  wire logic [4:0]  latch_rd_idx,
   output logic      [13:0] latch_rd_data,
   output logic             pvm_active,
   output logic             other_logic_reset,
   output logic             io_hiz
);
   spvp_link_if lk ();
   spvp_core_s  s_reg;
   spvp_core_s  s_next;
   logic [4:0]  code;
   spvp_cmd_e   kind;
   logic        cmd_done;
   logic        prot_rd;
   logic        row_ok;

   // bit sampler and edge finder for the link pins
   spvp_pin_sync u_sync (
      .clk_sys             (clk_sys),
      .rst                 (rst),
      .prog_serial_clock   (prog_serial_clock),
      .prog_serial_data_in (prog_serial_data_in),
      .mode_select_pin     (mode_select_pin),
      .lk                  (lk)
   );

   // programming data latches
   spvp_data_latch #(.WORD_W(14), .DEPTH(32)) u_latch (
      .clk_sys       (clk_sys),
      .lk            (lk),
      .latch_rd_idx  (latch_rd_idx),
      .latch_rd_data (latch_rd_data)
   );

   // map a five-bit code onto a command kind
   function automatic spvp_cmd_e decode(input logic [4:0] c);
      case (c)
         `SPVP_CMD_LOAD_CFG:   decode = SPVP_K_LOAD_CFG;
         `SPVP_CMD_LOAD_DATA:  decode = SPVP_K_LOAD_DATA;
         `SPVP_CMD_READ:       decode = SPVP_K_READ;
         `SPVP_CMD_INCR:       decode = SPVP_K_INCR;
         `SPVP_CMD_RST_ADDR:   decode = SPVP_K_RST_ADDR;
         `SPVP_CMD_BEGIN_INT:  decode = SPVP_K_BEGIN_INT;
         `SPVP_CMD_BEGIN_EXT:  decode = SPVP_K_BEGIN_EXT;
         `SPVP_CMD_END_EXT:    decode = SPVP_K_END_EXT;
         `SPVP_CMD_BULK_ERASE: decode = SPVP_K_BULK;
         `SPVP_CMD_ROW_ERASE:  decode = SPVP_K_ROW;
         default:              decode = SPVP_K_NONE;
      endcase
   endfunction

   // increment with wrap inside program space or inside config space
   function automatic logic [13:0] incr(input logic [13:0] a);
      if (a == `SPVP_PROG_TOP) begin
         incr = `SPVP_ADDR_RST;
      end else if (a == `SPVP_ADDR_TOP) begin
         incr = `SPVP_CFG_BASE;
      end else begin
         incr = a + 14'h0001;
      end
   endfunction

   // the incoming sixth bit would land in bit 5; only bits 4..0 decide
   assign code     = s_reg.sr[15:11];
   assign kind     = decode(code);
   assign cmd_done = lk.clk_fall && s_reg.st == SPVP_ST_CMD && s_reg.cnt == `SPVP_CMD_LAST;
   assign prot_rd  = !code_protect_n && s_reg.addr < `SPVP_CFG_BASE;
   assign row_ok   = s_reg.addr <= `SPVP_CFG_BASE && !prot_rd;

   // next-state logic of the whole interpreter
   always_comb begin
      s_next         = s_reg;
      s_next.lat_we  = 1'b0;
      s_next.strobes = 5'h00;
      if (!lk.mode_on) begin
         // outside the mode everything returns to its reset value
         s_next = '0;
      end else begin
         case (s_reg.st)
            SPVP_ST_CMD: begin
               if (lk.clk_fall) begin
                  s_next.sr  = {lk.data_bit, s_reg.sr[15:1]};
                  s_next.cnt = s_reg.cnt + 5'h01;
               end
               if (cmd_done) begin
                  s_next.cnt = 5'h00;
                  case (kind)
                     SPVP_K_LOAD_CFG: begin
                        s_next.addr   = `SPVP_CFG_BASE;
                        s_next.in_cfg = 1'b1;
                        s_next.st     = SPVP_ST_DIN;
                     end
                     SPVP_K_LOAD_DATA: begin
                        s_next.st = SPVP_ST_DIN;
                     end
                     SPVP_K_READ: begin
                        s_next.st      = SPVP_ST_DOUT;
                        s_next.rd_word = prot_rd ? 14'h0000 : mem_rd_data;
                     end
                     SPVP_K_INCR: begin
                        s_next.addr = incr(s_reg.addr);
                     end
                     SPVP_K_RST_ADDR: begin
                        s_next.addr   = `SPVP_ADDR_RST;
                        s_next.in_cfg = 1'b0;
                     end
                     SPVP_K_BEGIN_INT: begin
                        if (s_reg.loaded) begin
                           s_next.strobes[0] = 1'b1;
                           s_next.loaded     = 1'b0;
                        end
                     end
                     SPVP_K_BEGIN_EXT: begin
                        // external timing is refused for config words
                        if (s_reg.loaded && s_reg.addr < `SPVP_CFG_BASE) begin
                           s_next.strobes[1] = 1'b1;
                           s_next.loaded     = 1'b0;
                           s_next.ext_busy   = 1'b1;
                        end
                     end
                     SPVP_K_END_EXT: begin
                        if (s_reg.ext_busy) begin
                           s_next.strobes[2] = 1'b1;
                           s_next.ext_busy   = 1'b0;
                        end
                     end
                     SPVP_K_BULK: begin
                        s_next.strobes[3] = 1'b1;
                     end
                     SPVP_K_ROW: begin
                        s_next.strobes[4] = row_ok;
                     end
                     default: begin
                        s_next.st = SPVP_ST_CMD;
                     end
                  endcase
               end
            end
            SPVP_ST_DIN: begin
               // zero start, 14 data bits, zero stop: word ends in sr[14:1]
               if (lk.clk_fall) begin
                  s_next.sr  = {lk.data_bit, s_reg.sr[15:1]};
                  s_next.cnt = s_reg.cnt + 5'h01;
                  if (s_reg.cnt == `SPVP_FRAME_LAST) begin
                     s_next.cnt      = 5'h00;
                     s_next.st       = SPVP_ST_CMD;
                     s_next.lat_we   = 1'b1;
                     s_next.lat_word = s_next.sr[14:1];
                     s_next.loaded   = 1'b1;
                  end
               end
            end
            SPVP_ST_DOUT: begin
               // new bit on each rise once driving; the emptied word gives the stop
               if (lk.clk_rise && s_reg.oe) begin
                  s_next.dout    = s_reg.rd_word[0];
                  s_next.rd_word = {1'b0, s_reg.rd_word[13:1]};
               end
               if (lk.clk_fall) begin
                  s_next.cnt = s_reg.cnt + 5'h01;
                  if (s_reg.cnt == 5'h00) begin
                     s_next.oe   = 1'b1;
                     s_next.dout = 1'b0;
                  end
                  if (s_reg.cnt == `SPVP_FRAME_LAST) begin
                     s_next.oe  = 1'b0;
                     s_next.cnt = 5'h00;
                     s_next.st  = SPVP_ST_CMD;
                  end
               end
            end
            default: begin
               s_next = '0;
            end
         endcase
      end
   end

   // state register
   always_ff @(posedge clk_sys) begin
      if (rst) begin
         s_reg <= '0;
      end else begin
         s_reg <= s_next;
      end
   end

   // outputs; latch slot follows the low five address bits
   assign lk.lat_we            = s_reg.lat_we;
   assign lk.lat_word          = s_reg.lat_word;
   assign lk.lat_idx           = s_reg.addr[4:0];
   assign mem_addr             = s_reg.addr;
   assign prog_serial_data_out = s_reg.dout;
   assign prog_serial_data_oe  = s_reg.oe;
   assign prog_begin_int       = s_reg.strobes[0];
   assign prog_begin_ext       = s_reg.strobes[1];
   assign prog_end_ext         = s_reg.strobes[2];
   assign bulk_erase           = s_reg.strobes[3];
   assign row_erase            = s_reg.strobes[4];
   // mode holds the rest of the chip in reset with its pins floating
   assign pvm_active           = lk.mode_on;
   assign other_logic_reset    = lk.mode_on;
   assign io_hiz               = lk.mode_on;

   // checks
   sequence s_cmd(logic [4:0] k);
      cmd_done && lk.mode_on && code == k;
   endsequence

   sequence s_read_go;
      s_reg.st == SPVP_ST_DOUT && !s_reg.oe && lk.clk_fall && s_reg.cnt == 5'h00;
   endsequence

   a_mode_exit_clear: assert property (@(posedge clk_sys) disable iff (rst)
      !lk.mode_on |=> s_reg.addr == `SPVP_ADDR_RST && !prog_serial_data_oe)
      else $error("mode exit did not clear address and release data pin");

   a_cfg_addr_load: assert property (@(posedge clk_sys) disable iff (rst)
      s_cmd(`SPVP_CMD_LOAD_CFG) |=> s_reg.addr == `SPVP_CFG_BASE && s_reg.st == SPVP_ST_DIN)
      else $error("load config did not set config base");

   a_incr_prog_wrap: assert property (@(posedge clk_sys) disable iff (rst)
      s_cmd(`SPVP_CMD_INCR) ##0 s_reg.addr == `SPVP_PROG_TOP |=> s_reg.addr == 14'h0000)
      else $error("program space increment did not wrap to zero");

   a_incr_cfg_wrap: assert property (@(posedge clk_sys) disable iff (rst)
      s_cmd(`SPVP_CMD_INCR) ##0 s_reg.addr == `SPVP_ADDR_TOP |=> s_reg.addr == `SPVP_CFG_BASE)
      else $error("config space increment did not wrap to config base");

   a_reset_addr_zero: assert property (@(posedge clk_sys) disable iff (rst)
      s_cmd(`SPVP_CMD_RST_ADDR) |=> s_reg.addr == 14'h0000 && !s_reg.in_cfg)
      else $error("reset address did not force zero");

   a_protect_read_zero: assert property (@(posedge clk_sys) disable iff (rst)
      s_cmd(`SPVP_CMD_READ) ##0 prot_rd |=> s_reg.rd_word == 14'h0000)
      else $error("protected read returned nonzero data");

   a_unknown_no_effect: assert property (@(posedge clk_sys) disable iff (rst)
      cmd_done && lk.mode_on && kind == SPVP_K_NONE
      |=> $stable(s_reg.addr) && !s_reg.lat_we && s_reg.st == SPVP_ST_CMD)
      else $error("unknown command changed state");

   a_read_drive_start: assert property (@(posedge clk_sys) disable iff (rst)
      s_read_go ##0 lk.mode_on |=> prog_serial_data_oe && !prog_serial_data_out)
      else $error("read frame did not start driving on first fall");

   a_read_release: assert property (@(posedge clk_sys) disable iff (rst)
      s_reg.st == SPVP_ST_DOUT && lk.clk_fall && s_reg.cnt == `SPVP_FRAME_LAST
      |=> !prog_serial_data_oe ##1 !prog_serial_data_oe)
      else $error("data pin not released after 16th fall");

   a_out_on_rise: assert property (@(posedge clk_sys) disable iff (rst)
      prog_serial_data_oe && !lk.clk_rise && lk.mode_on |=> $stable(prog_serial_data_out))
      else $error("read data changed away from a rising clock");

   a_sample_on_fall: assert property (@(posedge clk_sys) disable iff (rst)
      s_reg.st != SPVP_ST_DOUT && !lk.clk_fall && lk.mode_on |=> $stable(s_reg.sr))
      else $error("shift register moved without a falling clock");

   a_frame_latch: assert property (@(posedge clk_sys) disable iff (rst)
      s_reg.st == SPVP_ST_DIN && lk.clk_fall && s_reg.cnt == `SPVP_FRAME_LAST && lk.mode_on
      |=> s_reg.lat_we && s_reg.lat_word == $past(s_reg.sr[15:2]))
      else $error("frame end did not load the latch with the word");

   a_row_erase_gate: assert property (@(posedge clk_sys) disable iff (rst)
      row_erase |-> $past(s_reg.addr) <= `SPVP_CFG_BASE)
      else $error("row erase issued above config base");

   a_ext_cfg_block: assert property (@(posedge clk_sys) disable iff (rst)
      prog_begin_ext |-> $past(s_reg.addr) < `SPVP_CFG_BASE)
      else $error("external programming issued on config space");
endmodule // spvp_port

//--- tb/spvp_prog_model.sv
// programmer-side model: serial clock, data drive and read capture
`timescale 1ns/1ns
module spvp_prog_model (
   input  wire logic clk_sys,
   input  wire logic dev_oe,
   input  wire logic dev_dout,
   output logic      sclk,
   output logic      pin
);
   logic        drv_en;
   logic        drv;
   logic        float_val;
   logic [13:0] rd_word;
   logic [15:0] oe_mask;
   // clock and data held low before mode entry
   initial begin
      sclk = 1'b0;
      drv_en = 1'b1;
      drv = 1'b0;
      float_val = 1'b0;
   end
   // a released line has no pull, so it shows a toggling pattern
   always @(posedge clk_sys) float_val <= ~float_val;
   assign pin = dev_oe ? dev_dout : (drv_en ? drv : float_val);
   // one clock: data moves a cycle after rise, five high and three low cycles
   task automatic pulse_bit(input logic b, input logic rd, input int i);
      @(posedge clk_sys);
      sclk <= 1'b1;
      drv_en <= ~rd;
      @(posedge clk_sys);
      if (!rd) drv <= b;
      repeat (3) @(posedge clk_sys);
      @(negedge clk_sys);
      oe_mask[i] = dev_oe;
      if (i >= 1 && i <= 14) rd_word[i-1] = pin;
      @(posedge clk_sys) sclk <= 1'b0;
      repeat (2) @(posedge clk_sys);
   endtask
   // six command bits, low bit first, then the gap before any frame
   task automatic cmd(input logic [5:0] c);
      int i;
      for (i = 0; i < 6; i++) pulse_bit(c[i], 1'b0, i);
      repeat (8) @(posedge clk_sys);
   endtask
   // data frame: zero start, word low bit first, zero stop
   task automatic frame_out(input logic [13:0] w);
      int i;
      logic [15:0] f;
      f = {1'b0, w, 1'b0};
      for (i = 0; i < 16; i++) pulse_bit(f[i], 1'b0, i);
      repeat (8) @(posedge clk_sys);
   endtask
   // read frame: line released, bits captured while the clock is high
   task automatic frame_in();
      int i;
      for (i = 0; i < 16; i++) pulse_bit(1'b0, 1'b1, i);
      repeat (6) @(posedge clk_sys);
      drv <= 1'b0;
      drv_en <= 1'b1;
   endtask
endmodule // spvp_prog_model

//--- tb/tb_spvp_port.sv
// self-checking bench of the serial program/verify port
`timescale 1ns/1ns
module tb_spvp_port;
   logic        clk_sys;
   logic        rst;
   logic        mode_select_pin;
   logic        code_protect_n;
   logic [13:0] mem_rd_data;
   logic [4:0]  latch_rd_idx;
   logic        sclk;
   logic        pin;
   logic        dout;
   logic        oe;
   logic [13:0] mem_addr;
   logic [13:0] latch_rd_data;
   wire  [4:0]  pv;
   logic        pvm_active;
   logic        other_logic_reset;
   logic        io_hiz;
   logic [15:0] pc [5];
   int          miscompares;
   int          checks;
   spvp_port dut (
      .clk_sys(clk_sys), .rst(rst), .mode_select_pin(mode_select_pin),
      .prog_serial_clock(sclk), .prog_serial_data_in(pin),
      .prog_serial_data_out(dout), .prog_serial_data_oe(oe),
      .code_protect_n(code_protect_n), .mem_rd_data(mem_rd_data), .mem_addr(mem_addr),
      .prog_begin_int(pv[0]), .prog_begin_ext(pv[1]), .prog_end_ext(pv[2]),
      .bulk_erase(pv[3]), .row_erase(pv[4]), .latch_rd_idx(latch_rd_idx),
      .latch_rd_data(latch_rd_data), .pvm_active(pvm_active),
      .other_logic_reset(other_logic_reset), .io_hiz(io_hiz)
   );
   spvp_prog_model prog (
      .clk_sys(clk_sys), .dev_oe(oe), .dev_dout(dout), .sclk(sclk), .pin(pin)
   );
   // 25 MHz system clock
   initial begin
      clk_sys = 1'b0;
      forever #20 clk_sys = ~clk_sys;
   end
   // array stand-in: word is a fixed pattern of the address
   always @(posedge clk_sys) mem_rd_data <= mem_addr ^ 14'h2A5C;
   // strobe counters, one per kind
   always @(posedge clk_sys) for (int k = 0; k < 5; k++) pc[k] <= pc[k] + {15'h0, pv[k]};
   task automatic chk_w(input logic [15:0] got, input logic [15:0] exp, input string what);
      checks++;
      if (got !== exp) begin
         miscompares++;
         $display("mismatch at %0t: %s got %h expected %h", $time, what, got, exp);
      end
   endtask
   task automatic chk_b(input logic got, input logic exp, input string what);
      checks++;
      if (got !== exp) begin
         miscompares++;
         $display("mismatch at %0t: %s got %b expected %b", $time, what, got, exp);
      end
   endtask
   task automatic step(input int n);
      repeat (n) @(posedge clk_sys);
      #1;
   endtask
   // send a command and compare strobes {row, bulk, end, begin ext, begin int}
   task automatic do_cmd(input logic [5:0] c, input logic [4:0] exp);
      int k;
      // clear off the edge so the counters' own update cannot undo it
      #1;
      for (k = 0; k < 5; k++) pc[k] = 16'h0000;
      prog.cmd(c);
      step(1);
      for (k = 0; k < 5; k++) chk_w(pc[k], {15'h0, exp[k]}, "strobe count");
   endtask
   task automatic wr(input logic [13:0] w);
      prog.frame_out(w);
      step(1);
   endtask
   task automatic rd();
      prog.frame_in();
      step(1);
   endtask
   task automatic t_entry();
      chk_b(pvm_active, 1'b0, "mode before entry");
      @(posedge clk_sys) mode_select_pin <= 1'b1; // clock and data already low
      step(4);
      chk_b(pvm_active, 1'b1, "mode active");
      chk_b(other_logic_reset, 1'b1, "other logic reset");
      chk_b(io_hiz, 1'b1, "io floated");
      chk_b(oe, 1'b0, "pin released");
      chk_w({2'b00, mem_addr}, 16'h0000, "address cleared");
   endtask
   task automatic t_cfg();
      logic [5:0] unk [4] = '{6'h01, 6'h03, 6'h0C, 6'h3F};
      int i;
      do_cmd(6'h00, 5'h00); // load configuration
      wr(14'h1ABC);
      chk_w({2'b00, mem_addr}, 16'h2000, "cfg address");
      @(posedge clk_sys) latch_rd_idx <= 5'h00;
      step(2);
      chk_w({2'b00, latch_rd_data}, 16'h1ABC, "cfg word");
      do_cmd(6'h22, 5'h00); // load data with top bit set
      wr(14'h0123);
      chk_w({2'b00, mem_addr}, 16'h2000, "still in cfg");
      chk_w({2'b00, latch_rd_data}, 16'h0123, "data word");
      for (i = 0; i < 3; i++) do_cmd(6'h06, 5'h00);
      do_cmd(6'h26, 5'h00); // increment with top bit set
      chk_w({2'b00, mem_addr}, 16'h2004, "incremented");
      for (i = 0; i < 4; i++) do_cmd(unk[i], 5'h00);
      chk_w({2'b00, mem_addr}, 16'h2004, "unknown kept address");
      chk_w({2'b00, latch_rd_data}, 16'h0123, "unknown kept latch");
      do_cmd(6'h36, 5'h00); // reset address with top bit set
      chk_w({2'b00, mem_addr}, 16'h0000, "address reset");
   endtask
   task automatic t_prog();
      do_cmd(6'h08, 5'h01); // load left from the config scenario is consumed
      step(40); // internal program time
      do_cmd(6'h08, 5'h00); // begin without a load is ignored
      do_cmd(6'h02, 5'h00);
      wr(14'h0555);
      do_cmd(6'h08, 5'h01);
      step(40); // internal program time
      do_cmd(6'h02, 5'h00);
      wr(14'h0AAA);
      do_cmd(6'h18, 5'h02);
      do_cmd(6'h0A, 5'h04); // end inside the window
      do_cmd(6'h0A, 5'h00); // end without begin is ignored
      do_cmd(6'h09, 5'h08);
      @(posedge clk_sys) code_protect_n <= 1'b0;
      do_cmd(6'h11, 5'h00); // protected row erase ignored
      @(posedge clk_sys) code_protect_n <= 1'b1;
      do_cmd(6'h11, 5'h10);
      do_cmd(6'h00, 5'h00);
      wr(14'h3FFF);
      do_cmd(6'h18, 5'h00); // external begin refused in cfg space
      do_cmd(6'h11, 5'h10); // row erase at cfg start
      do_cmd(6'h06, 5'h00);
      do_cmd(6'h11, 5'h00); // above cfg start ignored
      do_cmd(6'h16, 5'h00);
   endtask
   task automatic t_read();
      do_cmd(6'h04, 5'h00);
      rd();
      chk_w({2'b00, prog.rd_word}, 16'h2A5C, "read word");
      chk_w(prog.oe_mask, 16'hFFFE, "drive span");
      chk_b(oe, 1'b0, "released after frame");
      do_cmd(6'h06, 5'h00);
      @(posedge clk_sys) code_protect_n <= 1'b0;
      do_cmd(6'h04, 5'h00);
      rd();
      chk_w({2'b00, prog.rd_word}, 16'h0000, "protected read");
      do_cmd(6'h00, 5'h00);
      wr(14'h0000);
      do_cmd(6'h24, 5'h00); // read with top bit set
      rd();
      chk_w({2'b00, prog.rd_word}, 16'h0A5C, "cfg read");
      @(posedge clk_sys) code_protect_n <= 1'b1;
   endtask
   task automatic t_exit();
      @(posedge clk_sys) mode_select_pin <= 1'b0;
      step(4);
      chk_b(pvm_active, 1'b0, "mode left");
      @(posedge clk_sys) mode_select_pin <= 1'b1;
      step(4);
      chk_w({2'b00, mem_addr}, 16'h0000, "cfg left by exit");
      do_cmd(6'h08, 5'h00); // load memory cleared by exit
   endtask
   task automatic print_verdict();
      $display("checks %0d miscompares %0d", checks, miscompares);
      if (miscompares == 0 && checks > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask
   // watchdog cuts a hang short
   initial begin
      repeat (20000) @(posedge clk_sys);
      miscompares++;
      print_verdict();
   end
   // reset, then the scenarios
   initial begin
      rst = 1'b1;
      mode_select_pin = 1'b0;
      code_protect_n = 1'b1;
      latch_rd_idx = 5'h00;
      mem_rd_data = 14'h0000;
      miscompares = 0;
      checks = 0;
      repeat (12) @(posedge clk_sys);
      rst <= 1'b0;
      step(2);
      t_entry();
      t_cfg();
      t_prog();
      t_read();
      t_exit();
      print_verdict();
   end
endmodule // tb_spvp_port
